// [logic/srac_params.svh]
`ifndef SRAC_PARAMS_SVH
`define SRAC_PARAMS_SVH

// ****************************************************************
// Mode encodings and reset values.
// ****************************************************************
`define SRAC_MODE_NORMAL      2'h0
`define SRAC_MODE_FORCE_BAT   2'h1
`define SRAC_MODE_OFF_FLOAT   2'h2
`define SRAC_MODE_OFF_PULL    2'h3
`define SRAC_MODE_RESET       2'h0
`define SRAC_REGSEL_TRACK     3'h0
`define SRAC_REGSEL_RESET     3'h0
`define SRAC_VCODE_RESET      5'h00

// ****************************************************************
// Auxiliary output voltage arithmetic in millivolts.
// ****************************************************************
`define SRAC_AUX_BASE_MV      12'h258
`define SRAC_AUX_STEP_MV      12'h064
`define SRAC_AUX_MAX_MV       12'hE74

// ****************************************************************
// Rail tracking arithmetic in millivolts, gain in 1/1000 steps.
// ****************************************************************
`define SRAC_TRACK_GAIN       12'h417
`define SRAC_TRACK_DIV        24'h0003E8
`define SRAC_TRACK_FLOOR_MV   12'hED8

// ****************************************************************
// Current limit fault time.
// ****************************************************************
`define SRAC_ILIM_TIME_NS     1000000
`define SRAC_CLK_PERIOD_NS    10

`endif

// [logic/srac_pkg.sv]
package srac_pkg;

    typedef enum logic [1:0] {
        SRAC_AUX_PULLDOWN = 2'h0,
        SRAC_AUX_REGULATOR = 2'h1,
        SRAC_AUX_SWITCH = 2'h3
    } srac_aux_state_type;

    typedef struct packed {
        logic input_valid;
        logic input_above_uv;
        logic input_above_bat_slp;
        logic input_below_ov;
        logic battery_above_uv;
    } srac_sense_type;

    typedef struct packed {
        logic feed_from_input;
        logic feed_from_battery;
        logic pulldown_on;
    } srac_rail_type;

endpackage : srac_pkg

// [logic/srac_aux_volt.sv]
`timescale 1ns/100ps
`include "srac_params.svh"

module srac_aux_volt (
    // Code in and target out
    input  wire logic [4:0]  code_i,
    output logic      [11:0] target_mv_o
);

    logic [11:0] raw_mv;

    always_comb begin
        raw_mv = `SRAC_AUX_BASE_MV + 12'(code_i) * `SRAC_AUX_STEP_MV;
        if (raw_mv > `SRAC_AUX_MAX_MV) begin
            target_mv_o = `SRAC_AUX_MAX_MV;
        end else begin
            target_mv_o = raw_mv;
        end
    end

endmodule : srac_aux_volt

// [logic/srac_rail_track.sv]
`timescale 1ns/100ps
`include "srac_params.svh"

module srac_rail_track (
    // Battery voltage in and tracking target out
    input  wire logic [11:0] battery_mv_i,
    output logic      [11:0] target_mv_o
);

    logic [23:0] scaled;
    logic [23:0] track_full;
    logic [11:0] track_mv;

    always_comb begin
        scaled     = 24'(battery_mv_i) * 24'(`SRAC_TRACK_GAIN);
        track_full = scaled / `SRAC_TRACK_DIV;
        track_mv   = 12'(track_full);
        if (track_full > 24'(`SRAC_TRACK_FLOOR_MV)) begin
            if (24'(track_mv) != track_full) begin
                // Saturates instead of wrapping past the output range.
                target_mv_o = '1;
            end else begin
                target_mv_o = track_mv;
            end
        end else begin
            target_mv_o = `SRAC_TRACK_FLOOR_MV;
        end
    end

endmodule : srac_rail_track

// [logic/srac_top.sv]
`timescale 1ns/100ps
`include "srac_params.svh"

// Overview of operation
// - Rail mode resets to normal code 00.
// - Normal mode pulls rail down on reset/ship.
// - Mode 01 feeds rail from battery.
// - Mode 01 refused when battery undervoltage.
// - Battery undervoltage in 01 falls to 00.
// - Mode 01 stops charging.
// - Mode 10 floats rail, aux disabled.
// - Mode 11 pulls rail down, aux disabled.
// - Off modes left only by write/button reset.
// - Aux enable and select choose output kind.
// - Aux kind changes only while disabled.
// - Voltage code updates apply immediately.
// - Aux target 0.6V plus 100mV steps, saturating.
// - Disabled aux output gets its pull-down.
// - Current limit held 1 ms sets fault.
// - Rail regulation only with input in window.
// - Tracking target is max(1.047 battery, 3.8V).
// - Always-on supply on except ship mode.
module srac_top
    import srac_pkg::*;
#(
    parameter int ILIM_CYCLES = `SRAC_ILIM_TIME_NS / `SRAC_CLK_PERIOD_NS
) (
    // Clock, reset, enable
    input  wire logic            sys_clk_i,
    input  wire logic            srst_i,
    input  wire logic            clk_en_i,
    // Host configuration
    input  wire logic            mode_wr_i,
    input  wire logic [1:0]      mode_wdata_i,
    input  wire logic            aux_output_enable_i,
    input  wire logic            aux_output_switch_select_i,
    input  wire logic [4:0]      aux_output_voltage_code_i,
    input  wire logic [2:0]      rail_regulation_select_i,
    input  wire logic            fault_clear_i,
    // Device conditions
    input  wire srac_sense_type  sense_i,
    input  wire logic            hw_reset_i,
    input  wire logic            button_reset_i,
    input  wire logic            ship_mode_i,
    input  wire logic            charge_request_i,
    input  wire logic            aux_current_limit_i,
    input  wire logic [11:0]     battery_mv_i,
    // Rail and supply control
    output srac_rail_type        system_rail_o,
    output logic [1:0]           system_rail_mode_o,
    output logic                 charge_enable_o,
    output logic                 rail_regulation_active_o,
    output logic [11:0]          rail_target_mv_o,
    output logic                 always_on_enable_o,
    // Auxiliary output control
    output srac_aux_state_type   aux_state_o,
    output logic                 aux_pulldown_o,
    output logic [11:0]          aux_target_mv_o,
    output logic                 aux_fault_o,
    output logic                 aux_fault_event_o
);

    // ****************************************************************
    // Rail mode field.
    // ****************************************************************
    logic [1:0] mode_reg;
    logic [1:0] mode_next;

    always_comb begin
        mode_next = mode_reg;
        if (button_reset_i) begin
            mode_next = `SRAC_MODE_RESET;
        end else if (mode_wr_i) begin
            if (mode_wdata_i == `SRAC_MODE_FORCE_BAT &&
                !sense_i.battery_above_uv) begin
                mode_next = `SRAC_MODE_NORMAL;
            end else begin
                mode_next = mode_wdata_i;
            end
        end else if (mode_reg == `SRAC_MODE_FORCE_BAT &&
                     !sense_i.battery_above_uv) begin
            mode_next = `SRAC_MODE_NORMAL;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mode_reg <= `SRAC_MODE_RESET;
        end else if (clk_en_i) begin
            mode_reg <= mode_next;
        end
    end

    // ****************************************************************
    // Rail supply selection.
    // ****************************************************************
    srac_rail_type rail_next;
    logic          disconnect;

    always_comb begin
        disconnect = hw_reset_i || ship_mode_i;
        rail_next  = '0;
        case (mode_reg)
            `SRAC_MODE_NORMAL: begin
                if (disconnect) begin
                    rail_next.pulldown_on = 1'b1;
                end else if (sense_i.input_valid) begin
                    rail_next.feed_from_input = 1'b1;
                end else begin
                    rail_next.feed_from_battery = 1'b1;
                end
            end
            `SRAC_MODE_FORCE_BAT: begin
                if (disconnect) begin
                    rail_next.pulldown_on = 1'b1;
                end else begin
                    rail_next.feed_from_battery = 1'b1;
                end
            end
            `SRAC_MODE_OFF_FLOAT: begin
                rail_next = '0;
            end
            default: begin
                rail_next.pulldown_on = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            system_rail_o      <= '0;
            system_rail_mode_o <= `SRAC_MODE_RESET;
            charge_enable_o    <= 1'b0;
            always_on_enable_o <= 1'b1;
        end else if (clk_en_i) begin
            system_rail_o      <= rail_next;
            system_rail_mode_o <= mode_next;
            charge_enable_o    <= charge_request_i &&
                                  mode_next == `SRAC_MODE_NORMAL;
            always_on_enable_o <= !ship_mode_i;
        end
    end

    // ****************************************************************
    // Rail regulation target.
    // ****************************************************************
    logic [11:0] track_mv;
    logic        reg_window;

    srac_rail_track u_track (
        .battery_mv_i (battery_mv_i),
        .target_mv_o  (track_mv)
    );

    always_comb begin
        reg_window = sense_i.input_above_uv &&
                     sense_i.input_above_bat_slp &&
                     sense_i.input_below_ov;
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rail_regulation_active_o <= 1'b0;
            rail_target_mv_o         <= `SRAC_TRACK_FLOOR_MV;
        end else if (clk_en_i) begin
            rail_regulation_active_o <= reg_window &&
                                        rail_next.feed_from_input;
            if (rail_regulation_select_i == `SRAC_REGSEL_TRACK) begin
                rail_target_mv_o <= track_mv;
            end
        end
    end

    // ****************************************************************
    // Auxiliary output mode.
    // ****************************************************************
    logic aux_allowed;
    logic aux_on;

    always_comb begin
        aux_allowed = mode_reg == `SRAC_MODE_NORMAL ||
                      mode_reg == `SRAC_MODE_FORCE_BAT;
        aux_on      = aux_output_enable_i && aux_allowed;
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            aux_state_o    <= SRAC_AUX_PULLDOWN;
            aux_pulldown_o <= 1'b1;
        end else if (clk_en_i) begin
            if (!aux_on) begin
                aux_state_o    <= SRAC_AUX_PULLDOWN;
                aux_pulldown_o <= 1'b1;
            end else begin
                aux_pulldown_o <= 1'b0;
                if (aux_state_o == SRAC_AUX_PULLDOWN) begin
                    // Kind is latched only when leaving the disabled state.
                    if (aux_output_switch_select_i) begin
                        aux_state_o <= SRAC_AUX_SWITCH;
                    end else begin
                        aux_state_o <= SRAC_AUX_REGULATOR;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Auxiliary output voltage.
    // ****************************************************************
    logic [11:0] aux_mv;

    srac_aux_volt u_volt (
        .code_i      (aux_output_voltage_code_i),
        .target_mv_o (aux_mv)
    );

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            aux_target_mv_o <= `SRAC_AUX_BASE_MV;
        end else if (clk_en_i) begin
            aux_target_mv_o <= aux_mv;
        end
    end

    // ****************************************************************
    // Current limit fault timer.
    // ****************************************************************
    logic [31:0] ilim_cnt_reg;
    logic        ilim_expired;

    always_comb begin
        ilim_expired = ilim_cnt_reg >= 32'(ILIM_CYCLES - 1);
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ilim_cnt_reg <= '0;
        end else if (clk_en_i) begin
            if (!aux_current_limit_i || aux_state_o == SRAC_AUX_PULLDOWN) begin
                ilim_cnt_reg <= '0;
            end else if (!ilim_expired) begin
                ilim_cnt_reg <= ilim_cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            aux_fault_o       <= 1'b0;
            aux_fault_event_o <= 1'b0;
        end else if (clk_en_i) begin
            aux_fault_event_o <= 1'b0;
            if (ilim_expired && aux_current_limit_i &&
                aux_state_o != SRAC_AUX_PULLDOWN) begin
                if (!aux_fault_o) begin
                    aux_fault_event_o <= 1'b1;
                end
                aux_fault_o <= 1'b1;
            end else if (fault_clear_i) begin
                aux_fault_o <= 1'b0;
            end
        end
    end

endmodule : srac_top

// [sim/srac_checker.sv]
`timescale 1ns/100ps

// ****************************************************************
// Port checker for the rail and auxiliary output control.
// ****************************************************************
module srac_checker
    import srac_pkg::*;
#(
    parameter int ILIM_CYCLES = 10
) (
    // Inputs
    input  wire logic               sys_clk_i,
    input  wire logic               srst_i,
    input  wire logic               clk_en_i,
    input  wire logic               mode_wr_i,
    input  wire logic [1:0]         mode_wdata_i,
    input  wire logic               button_reset_i,
    input  wire srac_sense_type     sense_i,
    input  wire logic               ship_mode_i,
    input  wire logic               aux_output_enable_i,
    input  wire logic [4:0]         aux_output_voltage_code_i,
    input  wire logic [2:0]         rail_regulation_select_i,
    input  wire logic               aux_current_limit_i,
    input  wire logic [11:0]        battery_mv_i,
    // Outputs
    input  wire srac_rail_type      system_rail_o,
    input  wire logic [1:0]         system_rail_mode_o,
    input  wire logic               charge_enable_o,
    input  wire logic [11:0]        rail_target_mv_o,
    input  wire logic               always_on_enable_o,
    input  wire srac_aux_state_type aux_state_o,
    input  wire logic               aux_pulldown_o,
    input  wire logic [11:0]        aux_target_mv_o,
    input  wire logic               aux_fault_o,
    input  wire logic               aux_fault_event_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    function automatic logic [11:0] trk(input logic [11:0] b);
        logic [23:0] p;
        p = 24'(b) * 24'h417 / 24'h3E8;
        return (p > 24'hFFF) ? 12'hFFF : (p > 24'hED8) ? p[11:0] : 12'hED8;
    endfunction : trk

    a_force_taken: assert property (
        mode_wr_i && clk_en_i && mode_wdata_i == 2'h1 && !button_reset_i
        && sense_i.battery_above_uv |=> system_rail_mode_o == 2'h1)
        else $error("force write lost");
    a_force_refused: assert property (
        mode_wr_i && clk_en_i && mode_wdata_i == 2'h1
        && !sense_i.battery_above_uv |=> system_rail_mode_o == 2'h0)
        else $error("force write not refused");
    a_fallback_normal: assert property (
        clk_en_i && system_rail_mode_o == 2'h1 && !mode_wr_i
        && !sense_i.battery_above_uv |=> system_rail_mode_o == 2'h0)
        else $error("no fallback");
    a_force_no_charge: assert property (
        system_rail_mode_o == 2'h1 |-> !charge_enable_o)
        else $error("charging in forced mode");
    a_rail_off: assert property (
        clk_en_i && system_rail_mode_o[1] && !mode_wr_i && !button_reset_i
        |=> system_rail_o == {2'b00, system_rail_mode_o[0]}
        && aux_state_o == SRAC_AUX_PULLDOWN)
        else $error("off mode wrong");
    a_aux_disabled: assert property (
        clk_en_i && !aux_output_enable_i
        |=> aux_pulldown_o && aux_state_o == SRAC_AUX_PULLDOWN)
        else $error("aux not pulled down");
    a_aux_target: assert property (
        clk_en_i |=> aux_target_mv_o
        == 12'h258 + 12'h064 * 12'($past(aux_output_voltage_code_i)))
        else $error("aux target wrong");
    a_fault_pulse: assert property (
        aux_fault_event_o && clk_en_i |-> aux_fault_o ##1 !aux_fault_event_o)
        else $error("fault event not one pulse");
    a_fault_cause: assert property (
        $rose(aux_fault_o) |-> aux_fault_event_o && $past(aux_current_limit_i))
        else $error("fault without limit");
    a_always_on: assert property (
        clk_en_i |=> always_on_enable_o == !$past(ship_mode_i))
        else $error("always-on wrong");
    a_track_target: assert property (
        clk_en_i && rail_regulation_select_i == 3'h0
        |=> rail_target_mv_o == trk($past(battery_mv_i)))
        else $error("track target wrong");
endmodule : srac_checker

bind srac_top srac_checker #(.ILIM_CYCLES(ILIM_CYCLES)) u_chk (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i),
    .mode_wr_i(mode_wr_i), .mode_wdata_i(mode_wdata_i),
    .button_reset_i(button_reset_i), .sense_i(sense_i),
    .ship_mode_i(ship_mode_i), .aux_output_enable_i(aux_output_enable_i),
    .aux_output_voltage_code_i(aux_output_voltage_code_i),
    .rail_regulation_select_i(rail_regulation_select_i),
    .aux_current_limit_i(aux_current_limit_i), .battery_mv_i(battery_mv_i),
    .system_rail_o(system_rail_o), .system_rail_mode_o(system_rail_mode_o),
    .charge_enable_o(charge_enable_o), .rail_target_mv_o(rail_target_mv_o),
    .always_on_enable_o(always_on_enable_o), .aux_state_o(aux_state_o),
    .aux_pulldown_o(aux_pulldown_o), .aux_target_mv_o(aux_target_mv_o),
    .aux_fault_o(aux_fault_o), .aux_fault_event_o(aux_fault_event_o)
);

// [sim/srac_top_test.sv]
`timescale 1ns/100ps

// ****************************************************************
// Directed bench for the rail and auxiliary output control.
// ****************************************************************
module srac_top_test;
    import srac_pkg::*;
    logic sys_clk_i, srst_i, clk_en_i, mode_wr_i, aux_output_enable_i;
    logic aux_output_switch_select_i, fault_clear_i, hw_reset_i;
    logic button_reset_i, ship_mode_i, charge_request_i, aux_current_limit_i;
    logic [1:0] mode_wdata_i, system_rail_mode_o;
    logic [4:0] aux_output_voltage_code_i;
    logic [2:0] rail_regulation_select_i;
    logic [11:0] battery_mv_i, rail_target_mv_o, aux_target_mv_o;
    srac_sense_type sense_i;
    srac_rail_type system_rail_o;
    srac_aux_state_type aux_state_o;
    logic charge_enable_o, rail_regulation_active_o, always_on_enable_o;
    logic aux_pulldown_o, aux_fault_o, aux_fault_event_o;
    int fails, samples_checked;

    srac_top #(.ILIM_CYCLES(10)) u_dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i),
        .mode_wr_i(mode_wr_i), .mode_wdata_i(mode_wdata_i),
        .aux_output_enable_i(aux_output_enable_i),
        .aux_output_switch_select_i(aux_output_switch_select_i),
        .aux_output_voltage_code_i(aux_output_voltage_code_i),
        .rail_regulation_select_i(rail_regulation_select_i),
        .fault_clear_i(fault_clear_i), .sense_i(sense_i),
        .hw_reset_i(hw_reset_i), .button_reset_i(button_reset_i),
        .ship_mode_i(ship_mode_i), .charge_request_i(charge_request_i),
        .aux_current_limit_i(aux_current_limit_i), .battery_mv_i(battery_mv_i),
        .system_rail_o(system_rail_o), .system_rail_mode_o(system_rail_mode_o),
        .charge_enable_o(charge_enable_o),
        .rail_regulation_active_o(rail_regulation_active_o),
        .rail_target_mv_o(rail_target_mv_o),
        .always_on_enable_o(always_on_enable_o), .aux_state_o(aux_state_o),
        .aux_pulldown_o(aux_pulldown_o), .aux_target_mv_o(aux_target_mv_o),
        .aux_fault_o(aux_fault_o), .aux_fault_event_o(aux_fault_event_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic w(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : w

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] m);
        w(1);
        mode_wr_i <= 1'b1;
        mode_wdata_i <= m;
        w(1);
        mode_wr_i <= 1'b0;
        w(2);
        #1;
    endtask : wr

    task automatic t_reset();
        chk(12'(system_rail_mode_o), 12'h0);
        chk(12'(system_rail_o), 12'h4);
        chk(12'(always_on_enable_o), 12'h1);
        chk(12'(aux_pulldown_o), 12'h1);
        chk(aux_target_mv_o, 12'h258);
        w(1);
        ship_mode_i <= 1'b1;
        w(2);
        #1;
        chk(12'(always_on_enable_o), 12'h0);
        chk(12'(system_rail_o), 12'h1);
        w(1);
        ship_mode_i <= 1'b0;
        hw_reset_i <= 1'b1;
        w(2);
        #1;
        chk(12'(system_rail_o), 12'h1);
        w(1);
        hw_reset_i <= 1'b0;
        aux_output_enable_i <= 1'b1;
    endtask : t_reset

    task automatic t_force();
        wr(2'h1);
        chk(12'(system_rail_mode_o), 12'h1);
        chk(12'(system_rail_o), 12'h2);
        chk(12'(charge_enable_o), 12'h0);
        w(1);
        sense_i.battery_above_uv <= 1'b0;
        w(2);
        #1;
        chk(12'(system_rail_mode_o), 12'h0);
        wr(2'h1);
        chk(12'(system_rail_mode_o), 12'h0);
        w(1);
        sense_i.battery_above_uv <= 1'b1;
    endtask : t_force

    task automatic t_off();
        for (int m = 2; m < 4; m++) begin
            wr(2'(m));
            chk(12'(system_rail_o), 12'(m - 2));
            chk(12'(aux_pulldown_o), 12'h1);
            w(1);
            hw_reset_i <= 1'b1;
            w(2);
            #1;
            chk(12'(system_rail_mode_o), 12'(m));
            w(1);
            hw_reset_i <= 1'b0;
            button_reset_i <= 1'b1;
            w(1);
            button_reset_i <= 1'b0;
            w(2);
            #1;
            chk(12'(system_rail_mode_o), 12'h0);
        end
    endtask : t_off

    task automatic t_aux();
        w(1);
        aux_output_voltage_code_i <= 5'h1F;
        w(2);
        #1;
        chk(12'(aux_state_o), 12'(SRAC_AUX_REGULATOR));
        chk(aux_target_mv_o, 12'hE74);
        w(1);
        aux_output_switch_select_i <= 1'b1;
        aux_output_voltage_code_i <= 5'h07;
        w(2);
        #1;
        chk(12'(aux_state_o), 12'(SRAC_AUX_REGULATOR));
        chk(aux_target_mv_o, 12'h514);
        w(1);
        aux_output_enable_i <= 1'b0;
        w(2);
        #1;
        chk(12'(aux_pulldown_o), 12'h1);
        w(1);
        aux_output_enable_i <= 1'b1;
        w(2);
        #1;
        chk(12'(aux_state_o), 12'(SRAC_AUX_SWITCH));
    endtask : t_aux

    task automatic t_fault();
        w(1);
        aux_current_limit_i <= 1'b1;
        w(9);
        #1;
        chk(12'(aux_fault_o), 12'h0);
        w(1);
        #1;
        chk(12'(aux_fault_event_o), 12'h1);
        chk(12'(aux_fault_o), 12'h1);
        w(4);
        #1;
        chk(12'(aux_fault_event_o), 12'h0);
        chk(12'(aux_fault_o), 12'h1);
        w(1);
        aux_current_limit_i <= 1'b0;
        fault_clear_i <= 1'b1;
        w(1);
        fault_clear_i <= 1'b0;
        w(1);
        #1;
        chk(12'(aux_fault_o), 12'h0);
    endtask : t_fault

    task automatic t_track();
        chk(rail_target_mv_o, 12'hF8A);
        chk(12'(rail_regulation_active_o), 12'h1);
        w(1);
        clk_en_i <= 1'b0;
        battery_mv_i <= 12'hBB8;
        sense_i.input_below_ov <= 1'b0;
        w(2);
        #1;
        chk(rail_target_mv_o, 12'hF8A);
        chk(12'(rail_regulation_active_o), 12'h1);
        w(1);
        clk_en_i <= 1'b1;
        rail_regulation_select_i <= 3'h1;
        w(2);
        #1;
        chk(rail_target_mv_o, 12'hF8A);
        chk(12'(rail_regulation_active_o), 12'h0);
        w(1);
        rail_regulation_select_i <= 3'h0;
        w(2);
        #1;
        chk(rail_target_mv_o, 12'hED8);
    endtask : t_track

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    initial begin
        w(3000);
        fails++;
        give_verdict();
    end

    initial begin
        fails = 0;
        samples_checked = 0;
        {srst_i, clk_en_i, charge_request_i, aux_output_enable_i} = 4'hE;
        {mode_wr_i, mode_wdata_i, aux_output_switch_select_i} = 4'h0;
        {fault_clear_i, hw_reset_i, button_reset_i, ship_mode_i} = 4'h0;
        aux_current_limit_i = 1'b0;
        aux_output_voltage_code_i = 5'h00;
        rail_regulation_select_i = 3'h0;
        sense_i = 5'h1F;
        battery_mv_i = 12'hED8;
        w(20);
        srst_i <= 1'b0;
        w(2);
        #1;
        t_reset();
        t_force();
        t_off();
        t_aux();
        t_fault();
        t_track();
        give_verdict();
    end
endmodule : srac_top_test
